// File: flm_pkg.sv
// Shared types and constants for the fault latch and reset manager
package flm_pkg;

  // ==========================================================
  // Reset mode, fault category and control channel encodings
  // ==========================================================
  typedef enum logic [1:0] {
    FLM_MODE_MANUAL,
    FLM_MODE_AUTO,
    FLM_MODE_REMOTE
  } flm_mode_t;

  typedef enum logic [2:0] {
    FLM_CAT_DIAG,
    FLM_CAT_WIRING,
    FLM_CAT_INTERNAL,
    FLM_CAT_THERMAL,
    FLM_CAT_PROTECT,
    FLM_CAT_COMM
  } flm_cat_t;

  typedef enum logic [1:0] {
    FLM_CH_TERMINAL,
    FLM_CH_PANEL,
    FLM_CH_NETWORK
  } flm_chan_t;

  // ==========================================================
  // Reset values and sizes
  // ==========================================================
  localparam flm_mode_t MODE_RESET = FLM_MODE_MANUAL;
  localparam int NUM_FAULTS = 8;
  localparam int TIMEOUT_W = 16;
  localparam int CAP_W = 8;

  // ==========================================================
  // Timing: countdowns step once per tick
  // ==========================================================
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

endpackage

// File: flm_tick_div.sv
// Free running divider that makes the countdown tick
module flm_tick_div #(
  parameter int DIV = flm_pkg::TICK_CYCLES
) (
  input wire logic ref_clk, // System clock
  input wire logic rstn,    // Async reset, active low
  output logic tick         // One cycle pulse every DIV cycles
);
  import flm_pkg::*;

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_q;

  // ==========================================================
  // Divider counter
  // ==========================================================
  // Wraps at LAST so the tick period is exactly DIV cycles
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (cnt_q == LAST);
      cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
    end
  end

endmodule

// File: flm_fault_slot.sv
// One latched fault with its reset timeout countdown
module flm_fault_slot #(
  parameter int TW = flm_pkg::TIMEOUT_W
) (
  input wire logic ref_clk,          // System clock
  input wire logic rstn,             // Async reset, active low
  input wire logic detect,           // Fault condition with response taken
  input wire logic restore_load,     // First cycle after power-up
  input wire logic restore_val,      // Retained state from storage
  input wire logic clr_now,          // Power cycle clear, no countdown
  input wire logic clr_req,          // Qualified reset request
  input wire logic tick,             // Countdown step
  input wire logic [TW-1:0] timeout, // Reset timeout, zero for none
  output logic latched,              // Fault is latched
  output logic cnt_zero              // Countdown has expired
);
  import flm_pkg::*;

  logic [TW-1:0] cnt_q;
  logic newly;

  assign newly = detect & ~latched;
  assign cnt_zero = (cnt_q == '0);

  // ==========================================================
  // Latch
  // ==========================================================
  // Detection wins over any clear in the same cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      latched <= 1'b0;
    end else if (restore_load) begin
      latched <= detect | restore_val;
    end else if (detect) begin
      latched <= 1'b1;
    end else if (clr_now | (clr_req & cnt_zero)) begin
      latched <= 1'b0;
    end
  end

  // ==========================================================
  // Reset timeout countdown
  // ==========================================================
  // Restarted on every new latch, also for restored faults
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else if (newly | (restore_load & restore_val)) begin
      cnt_q <= timeout;
    end else if (tick & ~cnt_zero) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  a_hold_latch: assert property (@(posedge ref_clk) disable iff (!rstn)
    latched & ~clr_now & ~clr_req & ~restore_load |=> latched)
    else $error("latched fault cleared without reset");
  a_timeout_block: assert property (@(posedge ref_clk) disable iff (!rstn)
    latched & clr_req & ~clr_now & ~cnt_zero & ~restore_load |=> latched)
    else $error("reset taken before timeout expired");

endmodule

// File: flm_reset_mgr.sv
// Fault latching and reset arbitration for a motor protection relay
// How it works
// - A latched fault stays latched until an accepted reset clears it.
// - Reset mode is manual, automatic or remote; manual after reset.
// - Mode change is refused while any fault is latched.
// - Resets come from power, button, keypad, tool, input, network, auto.
// - Thermal faults clear only after countdown and capacity below threshold.
// - A fault with a timeout ignores all but power cycle resets until it reaches zero.
// - Internal faults clear only on a power cycle.
// - Diagnostic, wiring and internal faults are lost at power loss; others kept.
// - Automatic reset never clears internal, diagnostic or wiring faults.
// - Any local reset clears wiring and diagnostic faults.
// - Network reset clears diagnostic faults only on the network channel.
// - Network reset never clears wiring faults.
// - Two-wire with run held: accepted reset restarts motor at once.
// - In manual mode all network resets are ignored.
module flm_reset_mgr #(
  parameter int NF = flm_pkg::NUM_FAULTS,
  parameter int TW = flm_pkg::TIMEOUT_W,
  parameter int CW = flm_pkg::CAP_W,
  parameter int TICK_CYCLES = flm_pkg::TICK_CYCLES
) (
  input wire logic ref_clk,                         // System clock
  input wire logic rstn,                            // Async reset, active low
  input wire logic [NF-1:0] fault_detect,           // Fault conditions
  input wire flm_pkg::flm_cat_t [NF-1:0] fault_cat, // Category of each fault
  input wire logic [NF-1:0][TW-1:0] fault_timeout,  // Reset timeouts in ticks
  input wire logic [NF-1:0] nv_restore,             // Stored faults at power-up
  input wire logic power_cycle,                     // Control power returned
  input wire logic rst_front_btn,                   // Front reset button
  input wire logic rst_panel_key,                   // Panel keypad reset
  input wire logic rst_panel_tool,                  // Panel engineering tool
  input wire logic rst_logic_in,                    // Dedicated reset input
  input wire logic rst_net,                         // Network reset command
  input wire logic rst_auto,                        // Automatic reset request
  input wire flm_pkg::flm_chan_t ctrl_chan,         // Active control channel
  input wire logic [CW-1:0] thermal_used,           // Used thermal capacity
  input wire logic [CW-1:0] thermal_thr,            // Thermal reset threshold
  input wire logic mode_wr,                         // Mode write strobe
  input wire logic [1:0] mode_wr_val,               // Requested reset mode
  input wire logic two_wire,                        // Two-wire control
  input wire logic run_req,                         // Run request or start
  input wire logic stop_req,                        // Stop, three-wire only
  output flm_pkg::flm_mode_t reset_mode,            // Current reset mode
  output logic mode_rejected,                       // Mode write refused
  output logic [NF-1:0] fault_latched,              // Latched faults
  output logic fault_any,                           // Fault indication
  output logic [NF-1:0] nv_keep,                    // Faults to retain
  output logic reset_done,                          // A fault was cleared
  output logic motor_out                            // Motor output enable
);
  import flm_pkg::*;

  logic tick;
  logic boot_done_q;
  logic restore_load;
  logic local_rst;
  logic net_ok;
  logic auto_ok;
  logic thermal_ok;
  logic any_now;
  logic run3_q;
  logic only_net;
  logic only_auto;
  logic [NF-1:0] clr_now;
  logic [NF-1:0] clr_req;
  logic [NF-1:0] cnt_zero;
  logic [NF-1:0] retain;
  logic [NF-1:0] clearing;

  // ==========================================================
  // Countdown tick
  // ==========================================================
  flm_tick_div #(
    .DIV(TICK_CYCLES)
  ) u_tick (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .tick(tick)
  );

  // ==========================================================
  // Power-up
  // ==========================================================
  // Stored faults are loaded in the first cycle after release;
  // loading them under reset would sample a port asynchronously
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      boot_done_q <= 1'b0;
    end else begin
      boot_done_q <= 1'b1;
    end
  end

  assign restore_load = ~boot_done_q;

  // ==========================================================
  // Reset source qualification
  // ==========================================================
  assign local_rst = rst_front_btn | rst_panel_key | rst_panel_tool | rst_logic_in;
  assign net_ok = rst_net & (reset_mode != FLM_MODE_MANUAL);
  assign auto_ok = rst_auto & (reset_mode == FLM_MODE_AUTO);
  assign thermal_ok = (thermal_used < thermal_thr);
  assign only_net = rst_net & ~local_rst & ~power_cycle & ~rst_auto;
  assign only_auto = rst_auto & ~local_rst & ~power_cycle & ~rst_net;

  // Per-fault clear terms by category; unknown codes never clear
  always_comb begin
    for (int i = 0; i < NF; i++) begin
      clr_now[i] = 1'b0;
      clr_req[i] = 1'b0;
      retain[i] = 1'b0;
      unique case (fault_cat[i])
        FLM_CAT_DIAG: begin
          clr_now[i] = power_cycle;
          clr_req[i] = local_rst | (net_ok & (ctrl_chan == FLM_CH_NETWORK));
        end
        FLM_CAT_WIRING: begin
          clr_now[i] = power_cycle;
          clr_req[i] = local_rst;
        end
        FLM_CAT_INTERNAL: begin
          clr_now[i] = power_cycle;
        end
        FLM_CAT_THERMAL: begin
          clr_req[i] = (local_rst | net_ok | auto_ok) & thermal_ok;
          retain[i] = 1'b1;
        end
        FLM_CAT_PROTECT, FLM_CAT_COMM: begin
          clr_req[i] = local_rst | net_ok | auto_ok;
          retain[i] = 1'b1;
        end
        default: begin
          clr_req[i] = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Fault slots
  // ==========================================================
  for (genvar g = 0; g < NF; g++) begin : g_slot
    flm_fault_slot #(
      .TW(TW)
    ) u_slot (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .detect(fault_detect[g]),
      .restore_load(restore_load),
      .restore_val(nv_restore[g] & retain[g]),
      .clr_now(clr_now[g]),
      .clr_req(clr_req[g]),
      .tick(tick),
      .timeout(fault_timeout[g]),
      .latched(fault_latched[g]),
      .cnt_zero(cnt_zero[g])
    );

    a_internal_pc: assert property (@(posedge ref_clk) disable iff (!rstn)
      boot_done_q & fault_latched[g] & (fault_cat[g] == FLM_CAT_INTERNAL) & ~power_cycle
      |=> fault_latched[g])
      else $error("internal fault cleared without power cycle");
    a_power_keep: assert property (@(posedge ref_clk) disable iff (!rstn)
      restore_load & nv_restore[g] & retain[g] |=> fault_latched[g])
      else $error("retained fault lost at power-up");
    a_pc_drop: assert property (@(posedge ref_clk) disable iff (!rstn)
      boot_done_q & power_cycle & ~fault_detect[g]
      & (fault_cat[g] inside {FLM_CAT_DIAG, FLM_CAT_WIRING}) |=> ~fault_latched[g])
      else $error("diagnostic or wiring fault kept over power cycle");
    a_auto_block: assert property (@(posedge ref_clk) disable iff (!rstn)
      boot_done_q & only_auto & fault_latched[g]
      & (fault_cat[g] inside {FLM_CAT_INTERNAL, FLM_CAT_DIAG, FLM_CAT_WIRING})
      |=> fault_latched[g])
      else $error("automatic reset cleared a blocked category");
    a_local_wiring: assert property (@(posedge ref_clk) disable iff (!rstn)
      boot_done_q & local_rst & fault_latched[g] & cnt_zero[g] & ~fault_detect[g]
      & (fault_cat[g] inside {FLM_CAT_DIAG, FLM_CAT_WIRING}) |=> ~fault_latched[g])
      else $error("local reset did not clear wiring or diagnostic fault");
    a_net_diag: assert property (@(posedge ref_clk) disable iff (!rstn)
      boot_done_q & only_net & fault_latched[g] & (fault_cat[g] == FLM_CAT_DIAG)
      & (ctrl_chan != FLM_CH_NETWORK) |=> fault_latched[g])
      else $error("network reset cleared diagnostic fault off network channel");
    a_net_wiring: assert property (@(posedge ref_clk) disable iff (!rstn)
      boot_done_q & only_net & fault_latched[g] & (fault_cat[g] == FLM_CAT_WIRING)
      |=> fault_latched[g])
      else $error("network reset cleared wiring fault");
    a_net_manual: assert property (@(posedge ref_clk) disable iff (!rstn)
      boot_done_q & only_net & fault_latched[g] & (reset_mode == FLM_MODE_MANUAL)
      |=> fault_latched[g])
      else $error("network reset accepted in manual mode");
    a_thermal_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
      boot_done_q & ~power_cycle & fault_latched[g] & (fault_cat[g] == FLM_CAT_THERMAL)
      & ~thermal_ok |=> fault_latched[g])
      else $error("thermal fault cleared above threshold");
    a_thermal_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
      boot_done_q & rst_front_btn & fault_latched[g] & (fault_cat[g] == FLM_CAT_THERMAL)
      & thermal_ok & cnt_zero[g] & ~fault_detect[g] |=> ~fault_latched[g])
      else $error("qualified thermal reset not taken");

    // Positive cases: a dead network or automatic path would pass every hold check above
    a_net_remote: assert property (@(posedge ref_clk) disable iff (!rstn)
      boot_done_q & only_net & fault_latched[g] & cnt_zero[g] & ~fault_detect[g]
      & (fault_cat[g] == FLM_CAT_DIAG) & (ctrl_chan == FLM_CH_NETWORK)
      & (reset_mode != FLM_MODE_MANUAL) |=> ~fault_latched[g])
      else $error("network reset ignored for diagnostic fault on network channel");
    a_auto_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
      boot_done_q & only_auto & fault_latched[g] & cnt_zero[g] & ~fault_detect[g]
      & (reset_mode == FLM_MODE_AUTO) & (fault_cat[g] inside {FLM_CAT_PROTECT, FLM_CAT_COMM})
      |=> ~fault_latched[g])
      else $error("automatic reset ignored in automatic mode");
  end

  // ==========================================================
  // Indication and retention
  // ==========================================================
  assign any_now = |fault_latched;
  assign clearing = fault_latched & ~fault_detect & (clr_now | (clr_req & cnt_zero));

  // Indication lags the latches by one cycle, so it stays up while
  // any fault that did not qualify remains
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fault_any <= 1'b0;
      nv_keep <= '0;
      reset_done <= 1'b0;
    end else begin
      fault_any <= any_now;
      nv_keep <= fault_latched & retain;
      reset_done <= boot_done_q & (|clearing);
    end
  end

  a_indicate: assert property (@(posedge ref_clk) disable iff (!rstn)
    any_now |=> fault_any)
    else $error("fault indication dropped with a fault latched");
  // The done pulse must follow every clear, not just appear now and then
  a_done_pulse: assert property (@(posedge ref_clk) disable iff (!rstn)
    boot_done_q & (|clearing) |=> reset_done)
    else $error("fault cleared without done pulse");

  // ==========================================================
  // Reset mode
  // ==========================================================
  // Writes of the unused code are refused like a locked write
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reset_mode <= MODE_RESET;
      mode_rejected <= 1'b0;
    end else begin
      mode_rejected <= 1'b0;
      if (mode_wr) begin
        if (any_now || mode_wr_val > 2'(FLM_MODE_REMOTE)) begin
          mode_rejected <= 1'b1;
        end else begin
          reset_mode <= flm_mode_t'(mode_wr_val);
        end
      end
    end
  end

  a_mode_init: assert property (@(posedge ref_clk) disable iff (!rstn)
    ~boot_done_q |-> reset_mode == FLM_MODE_MANUAL)
    else $error("reset mode not manual after reset");
  a_mode_locked: assert property (@(posedge ref_clk) disable iff (!rstn)
    mode_wr & any_now |=> $stable(reset_mode) && mode_rejected)
    else $error("mode changed while faults latched");
  // Only three modes exist, so the spare code must never reach the register
  a_mode_illegal: assert property (@(posedge ref_clk) disable iff (!rstn)
    mode_wr & (mode_wr_val == 2'h3) |=> $stable(reset_mode) && mode_rejected)
    else $error("illegal reset mode accepted");

  // ==========================================================
  // Motor output
  // ==========================================================
  // Three-wire needs a fresh start after a fault; two-wire follows
  // the held run request, so a reset restarts the motor at once
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      run3_q <= 1'b0;
    end else if (any_now | stop_req) begin
      run3_q <= 1'b0;
    end else if (run_req) begin
      run3_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      motor_out <= 1'b0;
    end else begin
      motor_out <= ~any_now & (two_wire ? run_req : run3_q);
    end
  end

  a_two_wire: assert property (@(posedge ref_clk) disable iff (!rstn)
    two_wire & run_req & $fell(any_now) |=> motor_out)
    else $error("two-wire motor not restarted after reset");
  a_motor_off: assert property (@(posedge ref_clk) disable iff (!rstn)
    any_now |=> ~motor_out)
    else $error("motor enabled with a fault latched");
  // Three-wire must not restart on its own once the start latch is gone
  a_three_wire: assert property (@(posedge ref_clk) disable iff (!rstn)
    ~two_wire & ~run3_q & ~run_req |=> ~motor_out)
    else $error("three-wire motor restarted without a start");

endmodule

// File: flm_local_ctrl.sv
// Model of the local inputs, operator panel and network master issuing resets
module flm_local_ctrl (
  input wire logic ref_clk,       // System clock
  input wire logic rstn,          // Async reset, active low
  input wire logic req_v,         // Bench asks for one request
  input wire logic [2:0] req_src, // Which source raises it
  output logic power_cycle,       // Control power returned
  output logic rst_front_btn,     // Front reset button
  output logic rst_panel_key,     // Panel keypad reset
  output logic rst_panel_tool,    // Panel engineering tool
  output logic rst_logic_in,      // Dedicated reset input
  output logic rst_net,           // Network reset command
  output logic rst_auto           // Automatic reset request
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] src_q;
  // ==========================================================
  // Request pulses
  // ==========================================================
  // Registered copy of req_v, one cycle late; a held req_v holds the source line
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      src_q <= 7'h00;
    end else begin
      src_q <= req_v ? 7'h01 << req_src : 7'h00;
    end
  end
  // Fan out to the reset request lines
  assign {rst_auto, rst_net, rst_logic_in, rst_panel_tool, rst_panel_key, rst_front_btn, power_cycle} = src_q;
endmodule

// File: fault_latch_reset_manager_tb.sv
// Self-checking bench for the fault latch and reset manager
module fault_latch_reset_manager_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import flm_pkg::*;
  localparam int CAT_OF[8] = '{0, 1, 2, 3, 4, 5, 3, 4};
  localparam logic [7:0] RETAIN = 8'hf8;
  logic ref_clk = 1'b0, rstn = 1'b0, req_v = 1'b0, mode_wr = 1'b0;
  logic [2:0] req_s = 3'h0;
  logic [1:0] mode_wr_val = 2'h0;
  logic [7:0] fault_detect = 8'h00, nv_restore = 8'h00, thermal_used = 8'h00, thermal_thr = 8'h01;
  logic [7:0][15:0] tmo = '0;
  flm_cat_t [7:0] cats;
  flm_chan_t ctrl_chan = FLM_CH_TERMINAL;
  logic pc, fb, pk, pt, li, rn, ra, mode_rejected, fault_any, reset_done, motor_out;
  flm_mode_t reset_mode;
  logic [7:0] fault_latched, nv_keep, exp_l = 8'h00;
  logic [31:0] seed = 32'h439c986b, r;
  int n_errors = 0, checked = 0, md = 0, ch = 0;
  bit th_ok = 1;
  logic two_wire = 1'b1, run_req = 1'b1, stop_req = 1'b0;
  // ==========================================================
  // Clock, partner and design
  // ==========================================================
  always #5 ref_clk = ~ref_clk;
  initial for (int i = 0; i < 8; i++) cats[i] = flm_cat_t'(CAT_OF[i]);
  flm_local_ctrl u_far (.ref_clk(ref_clk), .rstn(rstn), .req_v(req_v), .req_src(req_s), .power_cycle(pc),
    .rst_front_btn(fb), .rst_panel_key(pk), .rst_panel_tool(pt), .rst_logic_in(li), .rst_net(rn), .rst_auto(ra));
  // Short tick keeps the countdown scenario brief
  flm_reset_mgr #(.TICK_CYCLES(4)) DUT (.ref_clk(ref_clk), .rstn(rstn), .fault_detect(fault_detect),
    .fault_cat(cats), .fault_timeout(tmo), .nv_restore(nv_restore), .power_cycle(pc), .rst_front_btn(fb),
    .rst_panel_key(pk), .rst_panel_tool(pt), .rst_logic_in(li), .rst_net(rn), .rst_auto(ra),
    .ctrl_chan(ctrl_chan), .thermal_used(thermal_used), .thermal_thr(thermal_thr), .mode_wr(mode_wr),
    .mode_wr_val(mode_wr_val), .two_wire(two_wire), .run_req(run_req), .stop_req(stop_req), .reset_mode(reset_mode),
    .mode_rejected(mode_rejected), .fault_latched(fault_latched), .fault_any(fault_any), .nv_keep(nv_keep),
    .reset_done(reset_done), .motor_out(motor_out));
  // ==========================================================
  // Reference model and helpers
  // ==========================================================
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Which source may clear a category under the present mode and channel
  function automatic bit can_clr(int c, int s);
    bit loc = s >= 1 && s <= 4;
    bit net = s == 5 && md != 0;
    bit aut = s == 6 && md == 1;
    case (c)
      0: return s == 0 || loc || (net && ch == 2);
      1: return s == 0 || loc;
      2: return s == 0;
      3: return (loc || net || aut) && th_ok;
      default: return loc || net || aut;
    endcase
  endfunction
  task automatic chk(logic [31:0] g, logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wrap_up();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Pulse one request source, blk marks slots still counting down
  task automatic do_req(int s, logic [7:0] blk);
    logic [7:0] clr;
    clr = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (exp_l[i] && can_clr(CAT_OF[i], s) && !(blk[i] && s != 0)) clr[i] = 1'b1;
    end
    @(posedge ref_clk);
    req_v <= 1'b1;
    req_s <= s[2:0];
    @(posedge ref_clk);
    req_v <= 1'b0;
    // The done pulse stands only in the cycle right after the clear
    @(posedge ref_clk);
    #1;
    exp_l &= ~clr;
    chk(fault_latched, exp_l);
    chk(reset_done, clr != 0);
    @(posedge ref_clk);
    #1;
    chk(fault_any, exp_l != 0);
    chk(motor_out, exp_l == 0 && two_wire);
  endtask
  task automatic inject(logic [7:0] m);
    @(posedge ref_clk);
    fault_detect <= m;
    @(posedge ref_clk);
    fault_detect <= 8'h00;
    @(posedge ref_clk);
    #1;
    exp_l |= m;
    chk(fault_latched, exp_l);
    chk(fault_any, exp_l != 0);
    chk(nv_keep, exp_l & RETAIN);
  endtask
  task automatic set_mode(int v);
    bit rej;
    rej = exp_l != 0 || v == 3;
    @(posedge ref_clk);
    mode_wr <= 1'b1;
    mode_wr_val <= v[1:0];
    @(posedge ref_clk);
    mode_wr <= 1'b0;
    #1;
    if (!rej) md = v;
    chk(reset_mode, md);
    chk(mode_rejected, rej);
  endtask
  // Power cycle then button leaves nothing latched
  task automatic clear_all();
    @(posedge ref_clk);
    thermal_used <= 8'h00;
    thermal_thr <= 8'h01;
    th_ok = 1;
    do_req(0, 8'h00);
    do_req(1, 8'h00);
  endtask
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk(reset_mode, FLM_MODE_MANUAL);
    chk(fault_latched, 8'h00);
    set_mode(3);
    // Every source against every mode and channel, random faults and thermal
    for (int t = 0; t < 63; t++) begin
      clear_all();
      set_mode((t / 7) % 3);
      ch = (t / 21) % 3;
      @(posedge ref_clk);
      ctrl_chan <= flm_chan_t'(ch);
      r = xs();
      inject(r[7:0]);
      set_mode(r[9:8]);
      @(posedge ref_clk);
      thermal_used <= r[23:16];
      thermal_thr <= r[31:24];
      th_ok = r[23:16] < r[31:24];
      do_req(t % 7, 8'h00);
    end
    // Countdown of three ticks must expire before a reset takes effect
    clear_all();
    @(posedge ref_clk);
    tmo[7] <= 16'h0003;
    inject(8'h80);
    do_req(1, 8'h80);
    repeat (16) @(posedge ref_clk);
    do_req(1, 8'h00);
    @(posedge ref_clk);
    tmo[7] <= 16'h0000;
    // Power loss keeps only retainable categories
    inject(8'hff);
    @(posedge ref_clk);
    rstn <= 1'b0;
    nv_restore <= exp_l & RETAIN;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    #1;
    exp_l &= RETAIN;
    md = 0;
    chk(fault_latched, exp_l);
    chk(reset_mode, FLM_MODE_MANUAL);
    @(posedge ref_clk);
    nv_restore <= 8'h00;
    do_req(4, 8'h00);
    // Three-wire: a cleared fault leaves the motor off until a fresh start
    @(posedge ref_clk);
    two_wire <= 1'b0;
    run_req <= 1'b0;
    inject(8'h10);
    do_req(1, 8'h00);
    @(posedge ref_clk);
    run_req <= 1'b1;
    @(posedge ref_clk);
    run_req <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk(motor_out, 1'b1);
    @(posedge ref_clk);
    stop_req <= 1'b1;
    @(posedge ref_clk);
    stop_req <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk(motor_out, 1'b0);
    wrap_up();
  end
  // Watchdog sized well above the roughly fifteen hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    wrap_up();
  end
endmodule
